// ### rtl/farsp_core.v
// fault supervision and bridge response for a sensorless motor driver
// assumes avalon-mm master on clk; fault inputs are asynchronous levels
//
// The Avalon-MM slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "farsp_regs.vh"

module farsp_core #(
    parameter DETECT_TO_CYC = `FARSP_DETECT_TO_CYC,
    parameter RETRY_CYC     = `FARSP_RETRY_CYC
) (
    input  wire        clk,
    input  wire        nrst,
    // avalon-mm slave
    input  wire [3:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    // asynchronous condition inputs
    input  wire        sw_lock_current_over,
    input  wire        detect_ramp_active,
    input  wire        detect_pulse_start,
    input  wire        detect_current_decayed,
    input  wire        backemf_below_stationary,
    input  wire        thermal_warning,
    input  wire        thermal_shutdown,
    input  wire        motor_supply_uv,
    input  wire        analog_supply_rail_uv,
    // outputs
    output reg  [2:0]  bridge_state,
    output reg         fault_alert_n,
    output reg         charge_pump_en,
    output reg         logic_reset_n,
    output reg         irq
);

    localparam CW = 27;

    // -------------------------------------------------------------------
    // synchronised inputs
    // -------------------------------------------------------------------
    // every pin-side level passes two flops, which adds two cycles of latency
    wire [8:0] s;
    farsp_sync #(.W(9)) farsp_sync_i (
        .clk      (clk),
        .nrst     (nrst),
        .async_in ({analog_supply_rail_uv, motor_supply_uv, thermal_shutdown,
                    thermal_warning, backemf_below_stationary, detect_current_decayed,
                    detect_pulse_start, detect_ramp_active, sw_lock_current_over}),
        .sync_out (s)
    );
    wire lock_over = s[0];
    wire ramp_on   = s[1];
    wire pulse_in  = s[2];
    wire decayed   = s[3];
    wire bemf_low  = s[4];
    wire warn      = s[5];
    wire shut      = s[6];
    wire uv_any    = s[7] | s[8];

    // configuration, sticky status and the flags of the fault state
    reg [10:0]   ctrl_q;
    reg [8:0]    status_q;
    reg [8:0]    mask_q;
    reg          lat_q;       // latched fault holding the bridge
    reg [2:0]    lat_br_q;
    reg          retry_q;     // retry in progress
    reg [2:0]    retry_br_q;
    reg [CW-1:0] retry_cnt_q;
    reg [CW-1:0] ramp_cnt_q;
    reg          ramp_to_q;   // timeout already reported for this ramp
    reg          pulse_q;
    reg          pending_q;   // previous pulse current not yet decayed
    reg          lock_q;

    wire [3:0] mode      = ctrl_q[`FARSP_CTRL_MODE_LSB+3:`FARSP_CTRL_MODE_LSB];
    wire       to_en     = ctrl_q[`FARSP_CTRL_TOEN_BIT];
    wire       measuring = ctrl_q[`FARSP_CTRL_MCMD_BIT] | ctrl_q[`FARSP_CTRL_MR_BIT]
                         | ctrl_q[`FARSP_CTRL_ML_BIT] | ctrl_q[`FARSP_CTRL_MKE_BIT];
    wire       pos_meas  = ctrl_q[`FARSP_CTRL_MCMD_BIT] | ctrl_q[`FARSP_CTRL_MR_BIT]
                         | ctrl_q[`FARSP_CTRL_ML_BIT];
    wire       bemf_meas = ctrl_q[`FARSP_CTRL_MCMD_BIT] | ctrl_q[`FARSP_CTRL_MKE_BIT];
    // a write lands at the edge where waitrequest is sampled low; read data
    // are captured one edge earlier so that they already stand at that edge
    wire       wr        = avs_write & ~avs_waitrequest;
    wire       rd        = avs_read & avs_waitrequest;
    wire       clr_cmd   = wr && avs_address == `FARSP_OFF_CTRL
                         && avs_writedata[`FARSP_CTRL_CLR_BIT];

    // maps the low two code bits onto a bridge state
    // latched and retry codes share this map, so both stay in step
    function [2:0] br_of;
        input [1:0] c;
        begin
            case (c)
                2'h0:    br_of = `FARSP_BR_HIZ;
                2'h1:    br_of = `FARSP_BR_RECIRC;
                2'h2:    br_of = `FARSP_BR_HSBRAKE;
                default: br_of = `FARSP_BR_LSBRAKE;
            endcase
        end
    endfunction

    // the one code that reports without acting; its alert holds until w1c
    function rep_only;
        input [3:0] m;
        begin
            rep_only = (m == 4'h8);
        end
    endfunction

    // -------------------------------------------------------------------
    // event decode
    // -------------------------------------------------------------------
    // lock acts on the rising edge only, so a held over-limit neither
    // restarts the retry wait nor re-latches after a clear
    wire lock_evt    = lock_over & ~lock_q;
    wire lock_latch  = lock_evt & (mode[3:2] == 2'b00);
    wire lock_retry  = lock_evt & (mode[3:2] == 2'b01);
    wire lock_report = lock_evt & (~mode[3] | rep_only(mode));
    // a ramp that outlasts the limit reports once, not on every cycle
    wire ramp_to     = ramp_on & ~ramp_to_q
                     & (ramp_cnt_q == DETECT_TO_CYC[CW-1:0] - 1'b1);
    wire to_evt      = ramp_to & to_en;
    wire mpos_evt    = ramp_to & pos_meas;
    // the first pulse only arms pending; a second one before decay is the fault
    wire rate_evt    = pulse_in & ~pulse_q & pending_q & to_en;
    wire mbemf_evt   = bemf_low & bemf_meas;
    wire hiz_latch   = to_evt | mpos_evt | rate_evt | mbemf_evt;
    wire warn_rep    = warn & ctrl_q[`FARSP_CTRL_OTWR_BIT];

    // status sets; the summary bit repeats any event of this cycle
    wire [8:0] set_v;
    assign set_v[`FARSP_ST_LOCK]  = lock_report;
    assign set_v[`FARSP_ST_TO_A]  = to_evt & ~measuring;
    assign set_v[`FARSP_ST_TO_B]  = to_evt & measuring;
    assign set_v[`FARSP_ST_RATE]  = rate_evt;
    assign set_v[`FARSP_ST_MPOS]  = mpos_evt;
    assign set_v[`FARSP_ST_MBEMF] = mbemf_evt;
    assign set_v[`FARSP_ST_WARN]  = warn_rep;
    assign set_v[`FARSP_ST_SHUT]  = shut;
    assign set_v[`FARSP_ST_CTRLF] = lock_report | to_evt | rate_evt | mpos_evt
                                  | mbemf_evt | warn_rep | shut;

    // -------------------------------------------------------------------
    // avalon slave: one wait cycle then the answer
    // -------------------------------------------------------------------
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end
        else
        begin
            // idles high; low for the one cycle after a request is seen
            avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
            if (rd)
            begin
                case (avs_address)
                    `FARSP_OFF_CTRL:   avs_readdata <= {21'h000000, 1'b0, ctrl_q[9:0]};
                    `FARSP_OFF_STATUS: avs_readdata <= {23'h000000, status_q};
                    `FARSP_OFF_MASK:   avs_readdata <= {23'h000000, mask_q};
                    `FARSP_OFF_STATE:  avs_readdata <= {26'h0000000, retry_q, lat_q,
                                                        fault_alert_n, bridge_state};
                    default:           avs_readdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // -------------------------------------------------------------------
    // registers, detection timers and fault state
    // -------------------------------------------------------------------
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl_q      <= `FARSP_CTRL_RESET;
            mask_q      <= `FARSP_MASK_RESET;
            status_q    <= 9'h000;
            lat_q       <= 1'b0;
            lat_br_q    <= `FARSP_BR_ACTIVE;
            retry_q     <= 1'b0;
            retry_br_q  <= `FARSP_BR_ACTIVE;
            retry_cnt_q <= {CW{1'b0}};
            ramp_cnt_q  <= {CW{1'b0}};
            ramp_to_q   <= 1'b0;
            pulse_q     <= 1'b0;
            pending_q   <= 1'b0;
            lock_q      <= 1'b0;
        end
        else if (uv_any)
        begin
            // supply loss resets all fault state and configuration
            ctrl_q      <= `FARSP_CTRL_RESET;
            mask_q      <= `FARSP_MASK_RESET;
            status_q    <= 9'h000;
            lat_q       <= 1'b0;
            retry_q     <= 1'b0;
            retry_cnt_q <= {CW{1'b0}};
            ramp_cnt_q  <= {CW{1'b0}};
            ramp_to_q   <= 1'b0;
            pending_q   <= 1'b0;
            lock_q      <= 1'b0;
        end
        else
        begin
            lock_q  <= lock_over;
            pulse_q <= pulse_in;
            if (wr && avs_address == `FARSP_OFF_CTRL)
                ctrl_q <= {1'b0, avs_writedata[9:0]};
            if (wr && avs_address == `FARSP_OFF_MASK)
                mask_q <= avs_writedata[8:0];
            // set wins over a write-one clear, so an event in the clearing
            // cycle is never lost
            if (wr && avs_address == `FARSP_OFF_STATUS)
                status_q <= (status_q & ~avs_writedata[8:0]) | set_v;
            else
                status_q <= status_q | set_v;
            // ramp duration timer
            // the count stops at the limit, so a long ramp cannot fire twice
            if (!ramp_on)
            begin
                ramp_cnt_q <= {CW{1'b0}};
                ramp_to_q  <= 1'b0;
            end
            else if (ramp_to)
                ramp_to_q <= 1'b1;
            else if (!ramp_to_q)
                ramp_cnt_q <= ramp_cnt_q + 1'b1;
            // a pulse leaves current pending until decay is seen
            // a new pulse outranks decay in one cycle, keeping the check armed
            if (pulse_in & ~pulse_q)
                pending_q <= 1'b1;
            else if (decayed)
                pending_q <= 1'b0;
            // latched faults; release needs clear and condition gone
            if (hiz_latch)
            begin
                lat_q    <= 1'b1;
                lat_br_q <= `FARSP_BR_HIZ;
            end
            else if (lock_latch)
            begin
                lat_q    <= 1'b1;
                lat_br_q <= br_of(mode[1:0]);
            end
            // a clear is refused while a latching condition is still present;
            // the pulse fault leaves no lasting condition and clears on command
            else if (clr_cmd && !lock_over && !bemf_low && !ramp_on && !shut)
                lat_q <= 1'b0;
            // retry timer; a new over-limit edge during retry restarts the wait
            if (lock_retry)
            begin
                retry_q     <= 1'b1;
                retry_br_q  <= br_of(mode[1:0]);
                retry_cnt_q <= {CW{1'b0}};
            end
            else if (retry_q)
            begin
                if (retry_cnt_q == RETRY_CYC[CW-1:0] - 1'b1)
                    retry_q <= 1'b0;
                else
                    retry_cnt_q <= retry_cnt_q + 1'b1;
            end
        end
    end

    // -------------------------------------------------------------------
    // registered outputs; thermal shutdown outranks other states
    // -------------------------------------------------------------------
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            bridge_state   <= `FARSP_BR_HIZ;
            fault_alert_n  <= 1'b1;
            charge_pump_en <= 1'b0;
            logic_reset_n  <= 1'b0;
            irq            <= 1'b0;
        end
        else
        begin
            charge_pump_en <= ~uv_any;
            logic_reset_n  <= ~uv_any;
            irq            <= |(status_q & mask_q);
            if (uv_any || shut)
                bridge_state <= `FARSP_BR_HIZ;
            else if (lat_q)
                bridge_state <= lat_br_q;
            else if (retry_q)
                bridge_state <= retry_br_q;
            else
                bridge_state <= `FARSP_BR_ACTIVE;
            // alert follows live faults and a report-only lock until cleared
            // under undervoltage the controller is held in reset, so the alert
            // is released rather than reporting a fault nobody can clear
            fault_alert_n <= uv_any | ~(lat_q | retry_q | shut | warn_rep
                             | (status_q[`FARSP_ST_LOCK] & rep_only(mode)));
        end
    end

endmodule // farsp_core

`default_nettype wire

// ### rtl/farsp_regs.vh
// constants of the fault action and response block
// assumes a 40 MHz clock and an avalon-mm slave with 32-bit words
`ifndef FARSP_REGS_VH
`define FARSP_REGS_VH

// -------------------------------------------------------------------
// register byte offsets
// -------------------------------------------------------------------
`define FARSP_OFF_CTRL    4'h0
`define FARSP_OFF_STATUS  4'h4
`define FARSP_OFF_MASK    4'h8
`define FARSP_OFF_STATE   4'hc

// -------------------------------------------------------------------
// control register fields
// -------------------------------------------------------------------
`define FARSP_CTRL_MODE_LSB   0
`define FARSP_CTRL_TOEN_BIT   4
`define FARSP_CTRL_OTWR_BIT   5
`define FARSP_CTRL_MCMD_BIT   6
`define FARSP_CTRL_MR_BIT     7
`define FARSP_CTRL_ML_BIT     8
`define FARSP_CTRL_MKE_BIT    9
`define FARSP_CTRL_CLR_BIT    10
`define FARSP_CTRL_RESET      11'h000

// -------------------------------------------------------------------
// status bits (sticky, write one to clear); mask has same layout
// -------------------------------------------------------------------
`define FARSP_ST_LOCK     0
`define FARSP_ST_TO_A     1
`define FARSP_ST_TO_B     2
`define FARSP_ST_RATE     3
`define FARSP_ST_MPOS     4
`define FARSP_ST_MBEMF    5
`define FARSP_ST_WARN     6
`define FARSP_ST_SHUT     7
`define FARSP_ST_CTRLF    8
`define FARSP_MASK_RESET  9'h000

// -------------------------------------------------------------------
// bridge states
// -------------------------------------------------------------------
`define FARSP_BR_ACTIVE   3'h0
`define FARSP_BR_HIZ      3'h1
`define FARSP_BR_RECIRC   3'h2
`define FARSP_BR_HSBRAKE  3'h3
`define FARSP_BR_LSBRAKE  3'h4

// -------------------------------------------------------------------
// timing
// -------------------------------------------------------------------
`define FARSP_CLK_HZ          40000000
`define FARSP_DETECT_TO_MS    500
`define FARSP_DETECT_TO_CYC   (`FARSP_DETECT_TO_MS * (`FARSP_CLK_HZ / 1000))
`define FARSP_RETRY_MS        500
`define FARSP_RETRY_CYC       (`FARSP_RETRY_MS * (`FARSP_CLK_HZ / 1000))

`endif

// ### rtl/farsp_sync.v
// two-flop synchroniser for a bundle of asynchronous levels
// assumes inputs come from pins or analog comparators
`timescale 1ns/1ps
`default_nettype none

module farsp_sync #(
    parameter W = 8
) (
    input  wire         clk,
    input  wire         nrst,
    input  wire [W-1:0] async_in,
    output reg  [W-1:0] sync_out
);

    reg [W-1:0] meta_q;

    // -------------------------------------------------------------------
    // two stages; first stage read only by the second
    // -------------------------------------------------------------------
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            meta_q   <= {W{1'b0}};
            sync_out <= {W{1'b0}};
        end
        else
        begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule // farsp_sync

`default_nettype wire

// ### test/farsp_core_props.sv
// port checker for farsp_core
// assumes bind onto farsp_core; every input is one of its ports
`timescale 1ns/1ps
`default_nettype none
`include "farsp_regs.vh"
module farsp_core_props #(
    parameter DETECT_TO_CYC = 50,
    parameter RETRY_CYC     = 50
) (
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic       avs_read,
    input wire logic       avs_write,
    input wire logic       avs_waitrequest,
    input wire logic       detect_ramp_active,
    input wire logic       thermal_shutdown,
    input wire logic       motor_supply_uv,
    input wire logic       analog_supply_rail_uv,
    input wire logic [2:0] bridge_state,
    input wire logic       fault_alert_n,
    input wire logic       charge_pump_en,
    input wire logic       logic_reset_n
);
    // -------------------------------------------------------------
    // assertions; six cycles covers the 3-cycle sync/act latency
    // -------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("no answer one cycle after request");
    a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_shut_hiz: assert property (thermal_shutdown [*6] |-> bridge_state == `FARSP_BR_HIZ)
        else $error("shutdown without hi-z");
    a_shut_alert: assert property (thermal_shutdown [*6] ##0 logic_reset_n |-> !fault_alert_n)
        else $error("shutdown not reported");
    a_supply_uv: assert property (motor_supply_uv [*6] |->
        !charge_pump_en && !logic_reset_n && bridge_state == `FARSP_BR_HIZ)
        else $error("supply undervoltage not in reset");
    a_rail_uv: assert property (analog_supply_rail_uv [*6] |->
        !charge_pump_en && !logic_reset_n && bridge_state == `FARSP_BR_HIZ)
        else $error("rail undervoltage not in reset");
    a_bridge_alert: assert property ((bridge_state != `FARSP_BR_ACTIVE && logic_reset_n) [*2]
        |-> !fault_alert_n)
        else $error("bridge off without alert");
    a_ramp_hold: assert property (detect_ramp_active [*4] ##0 !fault_alert_n |=> !fault_alert_n)
        else $error("fault released while ramp present");
    a_reset_quiet: assert property (!logic_reset_n [*2] |-> fault_alert_n)
        else $error("alert driven while held in reset");
    // main scenarios reached
    c_lsbrake: cover property (bridge_state == `FARSP_BR_LSBRAKE);
    c_uv: cover property (!charge_pump_en && !logic_reset_n);
    c_ramp: cover property (detect_ramp_active && !fault_alert_n);
endmodule // farsp_core_props

bind farsp_core farsp_core_props #(
    .DETECT_TO_CYC(DETECT_TO_CYC),
    .RETRY_CYC    (RETRY_CYC)
) farsp_core_props_i (
    .clk(clk), .nrst(nrst), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .detect_ramp_active(detect_ramp_active),
    .thermal_shutdown(thermal_shutdown), .motor_supply_uv(motor_supply_uv),
    .analog_supply_rail_uv(analog_supply_rail_uv), .bridge_state(bridge_state),
    .fault_alert_n(fault_alert_n), .charge_pump_en(charge_pump_en),
    .logic_reset_n(logic_reset_n)
);
`default_nettype wire

// ### test/farsp_ctrl_model.sv
// system controller model watching the fault alert pin
// assumes the same clock and reset as the core
`timescale 1ns/1ps
`default_nettype none
module farsp_ctrl_model (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       fault_alert_n,
    output var  logic [7:0] alert_count_q
);
    logic prev_q;
    // count alert assertions; the bench checks the total at the end of its run
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            prev_q        <= 1'h1;
            alert_count_q <= 8'h00;
        end
        else
        begin
            prev_q <= fault_alert_n;
            if (prev_q && !fault_alert_n)
                alert_count_q <= alert_count_q + 8'h01;
        end
    end
endmodule // farsp_ctrl_model
`default_nettype wire

// ### test/fault_action_response_tb_top.sv
// self-checking bench for farsp_core with a controller model
// assumes short detect and retry counts so the run stays brief
`timescale 1ns/1ps
`default_nettype none
`include "farsp_regs.vh"
module fault_action_response_tb_top;
    localparam DTO = 40;
    localparam RTY = 60;
    localparam [31:0] CLR = 32'h0000_0400;
    logic        clk = 1'h0;
    logic        nrst = 1'h0;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'h0;
    logic        avs_write = 1'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata, q;
    logic        avs_waitrequest, fault_alert_n, charge_pump_en, logic_reset_n, irq;
    logic [8:0]  cnd = 9'h008; // lock,ramp,pulse,decayed,bemf,warn,shut,supply,rail
    logic [2:0]  bridge_state;
    logic [7:0]  alert_count;
    integer      fail_count = 0;
    integer      tests_run = 0;
    integer      c;
    always #12.5 clk = ~clk;
    farsp_core #(.DETECT_TO_CYC(DTO), .RETRY_CYC(RTY)) farsp_core_i (
        .clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .sw_lock_current_over(cnd[0]),
        .detect_ramp_active(cnd[1]), .detect_pulse_start(cnd[2]),
        .detect_current_decayed(cnd[3]), .backemf_below_stationary(cnd[4]),
        .thermal_warning(cnd[5]), .thermal_shutdown(cnd[6]), .motor_supply_uv(cnd[7]),
        .analog_supply_rail_uv(cnd[8]), .bridge_state(bridge_state),
        .fault_alert_n(fault_alert_n), .charge_pump_en(charge_pump_en),
        .logic_reset_n(logic_reset_n), .irq(irq));
    farsp_ctrl_model farsp_ctrl_model_i (.clk(clk), .nrst(nrst),
        .fault_alert_n(fault_alert_n), .alert_count_q(alert_count));
    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    task close_out;
    begin
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    end
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e);
    begin
        tests_run = tests_run + 1;
        if (s !== e)
        begin
            fail_count = fail_count + 1;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    end
    endtask
    // one avalon cycle; request held until waitrequest is sampled low
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    begin
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= ~w;
        avs_write <= w;
        @(posedge clk);
        // no cycle count assumed; only the watchdog ends a wait
        while (avs_waitrequest !== 1'h0)
            @(posedge clk);
        q = avs_readdata;
        avs_read <= 1'h0;
        avs_write <= 1'h0;
        @(posedge clk);
    end
    endtask
    task go(input logic [8:0] v, input integer n);
    begin
        cnd <= v;
        repeat (n) @(posedge clk);
    end
    endtask
    task pins(input logic [2:0] b, input logic a);
    begin
        chk({28'h0, bridge_state, fault_alert_n}, {28'h0, b, a});
    end
    endtask
    function logic [2:0] brx(input logic [1:0] m);
    begin
        brx = (m == 2'h0) ? `FARSP_BR_HIZ : (m == 2'h1) ? `FARSP_BR_RECIRC :
              (m == 2'h2) ? `FARSP_BR_HSBRAKE : `FARSP_BR_LSBRAKE;
    end
    endfunction
    // raise a fault, check hi-z and status, then release it; lt 2 tries an early clear
    task fcase(input logic [31:0] ctl, input logic [8:0] v, input integer h,
               input logic [8:0] m, input integer lt);
    begin
        bus(1'h1, `FARSP_OFF_CTRL, ctl);
        go(v, h);
        pins(`FARSP_BR_HIZ, 1'h0);
        bus(1'h0, `FARSP_OFF_STATUS, 32'h0);
        chk({31'h0, |(q[8:0] & m)}, 32'h1);
        if (lt == 2)
        begin
            bus(1'h1, `FARSP_OFF_CTRL, ctl | CLR);
            go(v, 8);
            pins(`FARSP_BR_HIZ, 1'h0);
        end
        go(9'h008, 8);
        if (lt != 0)
        begin
            pins(`FARSP_BR_HIZ, 1'h0);
            bus(1'h1, `FARSP_OFF_CTRL, ctl | CLR);
            go(9'h008, 8);
        end
        pins(`FARSP_BR_ACTIVE, 1'h1);
        bus(1'h1, `FARSP_OFF_STATUS, 32'h1ff);
    end
    endtask
    // watchdog, far beyond the roughly one thousand cycles the tests take
    initial
    begin
        repeat (20000) @(posedge clk);
        fail_count = fail_count + 1;
        close_out;
    end
    // -------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------
    initial
    begin
        repeat (6) @(posedge clk);
        nrst <= 1'h1;
        @(posedge clk);
        bus(1'h0, `FARSP_OFF_CTRL, 32'h0);
        chk(q, 32'h0);
        bus(1'h0, `FARSP_OFF_MASK, 32'h0);
        chk(q, 32'h0);
        bus(1'h1, 4'h2, 32'hffff_ffff);
        bus(1'h0, 4'h2, 32'h0);
        chk(q, 32'h0);
        bus(1'h0, `FARSP_OFF_STATE, 32'h0);
        chk(q, 32'h8);
        bus(1'h1, `FARSP_OFF_MASK, 32'h1);
        // latched and retry codes; a clear under over-limit is ignored
        for (c = 0; c < 8; c = c + 1)
        begin
            bus(1'h1, `FARSP_OFF_CTRL, c);
            go(9'h009, 8);
            pins(brx(c[1:0]), 1'h0);
            chk({31'h0, irq}, 32'h1);
            if (c < 4)
            begin
                bus(1'h1, `FARSP_OFF_CTRL, c | CLR);
                go(9'h008, 8);
                pins(brx(c[1:0]), 1'h0);
                bus(1'h1, `FARSP_OFF_CTRL, c | CLR);
                go(9'h008, 8);
            end
            else
                go(9'h008, RTY + 8);
            pins(`FARSP_BR_ACTIVE, 1'h1);
            bus(1'h1, `FARSP_OFF_STATUS, 32'h1ff);
            go(9'h008, 2);
            chk({31'h0, irq}, 32'h0);
        end
        // report-only and no-action codes
        for (c = 8; c < 16; c = c + 1)
        begin
            bus(1'h1, `FARSP_OFF_CTRL, c);
            go(9'h009, 8);
            pins(`FARSP_BR_ACTIVE, c != 8);
            bus(1'h0, `FARSP_OFF_STATUS, 32'h0);
            chk({31'h0, q[0]}, {31'h0, c == 8});
            go(9'h008, 8);
            bus(1'h1, `FARSP_OFF_STATUS, 32'h1ff);
            go(9'h008, 4);
            pins(`FARSP_BR_ACTIVE, 1'h1);
        end
        fcase(32'h10, 9'h00a, DTO + 10, 9'h002, 2);
        // one pulse alone only arms the decay check; the next one faults
        go(9'h004, 4);
        go(9'h000, 8);
        pins(`FARSP_BR_ACTIVE, 1'h1);
        fcase(32'h10, 9'h004, 8, 9'h008, 1);
        fcase(32'h200, 9'h018, 8, 9'h020, 2);
        fcase(32'h90, 9'h00a, DTO + 10, 9'h016, 2);
        fcase(32'h0, 9'h048, 8, 9'h080, 0);
        // thermal warning silent unless its report bit is set
        go(9'h028, 8);
        pins(`FARSP_BR_ACTIVE, 1'h1);
        go(9'h008, 8);
        bus(1'h1, `FARSP_OFF_CTRL, 32'h20);
        go(9'h028, 8);
        pins(`FARSP_BR_ACTIVE, 1'h0);
        go(9'h008, 8);
        pins(`FARSP_BR_ACTIVE, 1'h1);
        // supply then rail undervoltage
        for (c = 7; c < 9; c = c + 1)
        begin
            go(9'h008 | (9'h001 << c), 8);
            chk({charge_pump_en, logic_reset_n, bridge_state}, {2'h0, `FARSP_BR_HIZ});
            go(9'h008, 8);
            chk({charge_pump_en, logic_reset_n, bridge_state}, {2'h3, `FARSP_BR_ACTIVE});
        end
        chk({24'h0, alert_count}, 32'hf);
        close_out;
    end
endmodule // fault_action_response_tb_top
`default_nettype wire
